/* hw/irq_defs.svh */
// Register map, field positions and reset values of the interrupt enable/flag unit
`ifndef IRQ_DEFS_SVH
`define IRQ_DEFS_SVH

// Register indices; byte address is four times the index
`define IDX_CORE_CTRL_B0   8'h0b
`define IDX_CORE_CTRL_B1   8'h8b
`define IDX_PERIPH_REQ     8'h0c
`define IDX_PERIPH_EN      8'h8c
`define IDX_EVT_STATUS     8'h40
`define IDX_EVT_MASK       8'h41
`define IDX_CONFIG         8'h42

// Core control register fields
`define BIT_GLOBAL_EN      7
`define BIT_PERIPH_GRP_EN  6
`define BIT_T0_EN          5
`define BIT_EXT_EN         4
`define BIT_PINCHG_EN      3
`define BIT_T0_FLAG        2
`define BIT_EXT_FLAG       1
`define BIT_PINCHG_FLAG    0

// Peripheral request/enable fields
`define BIT_NV_DONE        7
`define BIT_T2_MATCH       1
`define BIT_T1_OVF         0
`define PERIPH_IMPL_MASK   8'hef

// Event status layout: [7:0] peripheral, [10:8] pin change, ext pin, timer0
`define EVT_W              11
`define EVT_T0_POS         8
`define EVT_IMPL_MASK      11'h7ef

// Config register: bit 0 selects rising edge on the external pin
`define BIT_EXT_RISING     0

// Reset values
`define RST_BYTE           8'h00
`define RST_CONFIG         8'h01
`define RST_EVT            11'h000

`endif

/* hw/irq_pkg.sv */
// Types shared by the interrupt enable/flag unit
package irq_pkg;

  // Core interrupt control register as a packed record
  typedef struct packed {
    logic global_irq_enable;
    logic peripheral_group_enable;
    logic timer0_overflow_enable;
    logic ext_pin_irq_enable;
    logic pin_change_irq_enable;
    logic timer0_overflow_flag;
    logic ext_pin_irq_flag;
    logic pin_change_irq_flag;
  } core_ctrl_s;

  // Decoded register selection
  typedef enum {SEL_NONE, SEL_CORE, SEL_PREQ, SEL_PEN, SEL_STAT, SEL_MASK, SEL_CFG} reg_sel_e;

endpackage

/* hw/interrupt_enable_flag_unit.sv */
// Interrupt enable and flag registers with APB access and core request generation
//
// Overview of operation
// - Every flag sets on its source event whatever the enables hold.
// - Bit 7 of core control is the global enable; zero blocks CORE_IRQ but not EVT_IRQ.
// - Peripheral sources also need the peripheral group enable at core bit 6.
// - Core control holds timer0, pin-change and external pin enables and flags.
// - Peripheral enable bit 0 gates the timer1 overflow request.
// - Peripheral request bit 7 sets on write done and holds until cleared.
// - Peripheral request bit 1 flags a timer2 count to period match.
// - Core control answers at two addresses, one per bank, same storage.
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "irq_defs.svh"

module interrupt_enable_flag_unit
  import irq_pkg::*;
(
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RESET,
  // APB slave
  input  wire logic [11:0] PADDR,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [31:0] PWDATA,
  output var  logic [31:0] PRDATA,
  output var  logic        PREADY,
  output var  logic        PSLVERR,
  // Event sources, one-cycle pulses from same-clock logic
  input  wire logic        TIMER0_OVERFLOW,
  input  wire logic        PIN_CHANGE,
  input  wire logic [7:0]  PERIPH_EVENT,
  // External interrupt pin, asynchronous
  input  wire logic        EXT_IRQ_PIN,
  // Requests
  output var  logic        CORE_IRQ,
  output var  logic        EVT_IRQ
);

  // ****************************************************************
  // Decode helpers
  // ****************************************************************
  function automatic reg_sel_e decode(input logic [11:0] addr);
    logic [7:0] idx;
    idx = addr[9:2];
    decode = SEL_NONE;
    if (addr[11:10] == 2'b00 && addr[1:0] == 2'b00)
    begin
      unique case (idx)
        `IDX_CORE_CTRL_B0: decode = SEL_CORE;
        `IDX_CORE_CTRL_B1: decode = SEL_CORE;
        `IDX_PERIPH_REQ:   decode = SEL_PREQ;
        `IDX_PERIPH_EN:    decode = SEL_PEN;
        `IDX_EVT_STATUS:   decode = SEL_STAT;
        `IDX_EVT_MASK:     decode = SEL_MASK;
        `IDX_CONFIG:       decode = SEL_CFG;
        default:           decode = SEL_NONE;
      endcase
    end
  endfunction

  // Flag update: a source event always wins over a clearing write
  function automatic logic [7:0] flag_next(input logic [7:0] cur, input logic wr,
                                           input logic [7:0] wdat, input logic [7:0] evt);
    flag_next = (wr ? wdat : cur) | evt;
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  core_ctrl_s  core_q;
  logic [7:0]  preq_q;
  logic [7:0]  pen_q;
  logic [10:0] stat_q;
  logic [10:0] mask_q;
  logic [7:0]  cfg_q;
  logic        pin_meta_q;
  logic        pin_sync_q;
  logic        pin_prev_q;
  logic        pready_q;
  logic        pslverr_q;
  logic [31:0] prdata_q;
  logic        core_irq_q;
  logic        evt_irq_q;

  reg_sel_e    sel;
  logic        wr_en;
  logic        ext_evt;
  logic [7:0]  core_evt;
  logic [7:0]  periph_evt;
  logic [10:0] all_evt;
  logic [7:0]  core_wmask;
  logic [7:0]  rdata;
  logic        core_req;
  logic        periph_req;

  assign sel   = decode(PADDR);
  // Write lands only at the access edge where the answer is given
  assign wr_en = PSEL & PENABLE & PWRITE & pready_q;

  // ****************************************************************
  // External pin synchroniser and edge detect
  // ****************************************************************
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      pin_meta_q <= 1'b0;
      pin_sync_q <= 1'b0;
      pin_prev_q <= 1'b0;
    end
    else
    begin
      pin_meta_q <= EXT_IRQ_PIN;
      pin_sync_q <= pin_meta_q;
      pin_prev_q <= pin_sync_q;
    end
  end

  // Edge is taken from the second and third stages; the first may be metastable
  assign ext_evt = cfg_q[`BIT_EXT_RISING] ? (pin_sync_q & ~pin_prev_q)
                                          : (~pin_sync_q & pin_prev_q);

  // ****************************************************************
  // Event vectors
  // ****************************************************************
  always_comb
  begin
    core_evt = `RST_BYTE;
    core_evt[`BIT_T0_FLAG]     = TIMER0_OVERFLOW;
    core_evt[`BIT_EXT_FLAG]    = ext_evt;
    core_evt[`BIT_PINCHG_FLAG] = PIN_CHANGE;
  end

  // Unimplemented bit never sets
  assign periph_evt = PERIPH_EVENT & `PERIPH_IMPL_MASK;
  assign all_evt    = {PIN_CHANGE, ext_evt, TIMER0_OVERFLOW, periph_evt};

  // ****************************************************************
  // Core interrupt control register
  // ****************************************************************
  // Enables take the write as is; flags go through the event-wins merge
  assign core_wmask = {5'h1f, 3'h0};

  always_ff @(posedge CLK)
  begin
    if (RESET)
      core_q <= core_ctrl_s'(`RST_BYTE);
    else
      core_q <= core_ctrl_s'((((wr_en && sel == SEL_CORE) ? PWDATA[7:0] : core_q)
                              & core_wmask)
                             | flag_next(core_q & ~core_wmask, wr_en && sel == SEL_CORE,
                                         PWDATA[7:0] & ~core_wmask, core_evt));
  end

  // ****************************************************************
  // Peripheral request and enable registers
  // ****************************************************************
  always_ff @(posedge CLK)
  begin
    if (RESET)
      preq_q <= `RST_BYTE;
    else
      preq_q <= flag_next(preq_q, wr_en && sel == SEL_PREQ,
                          PWDATA[7:0] & `PERIPH_IMPL_MASK, periph_evt);
  end

  always_ff @(posedge CLK)
  begin
    if (RESET)
      pen_q <= `RST_BYTE;
    else if (wr_en && sel == SEL_PEN)
      pen_q <= PWDATA[7:0] & `PERIPH_IMPL_MASK;
  end

  // ****************************************************************
  // Event status, mask and configuration
  // ****************************************************************
  // Sticky status, write one to clear; a new event in the same cycle stays
  always_ff @(posedge CLK)
  begin
    if (RESET)
      stat_q <= `RST_EVT;
    else if (wr_en && sel == SEL_STAT)
      stat_q <= (stat_q & ~PWDATA[10:0]) | all_evt;
    else
      stat_q <= stat_q | all_evt;
  end

  always_ff @(posedge CLK)
  begin
    if (RESET)
      mask_q <= `RST_EVT;
    else if (wr_en && sel == SEL_MASK)
      mask_q <= PWDATA[10:0] & `EVT_IMPL_MASK;
  end

  always_ff @(posedge CLK)
  begin
    if (RESET)
      cfg_q <= `RST_CONFIG;
    else if (wr_en && sel == SEL_CFG)
      cfg_q <= {7'h00, PWDATA[`BIT_EXT_RISING]};
  end

  // ****************************************************************
  // Request generation
  // ****************************************************************
  assign core_req = (core_q.timer0_overflow_enable & core_q.timer0_overflow_flag)
                  | (core_q.ext_pin_irq_enable & core_q.ext_pin_irq_flag)
                  | (core_q.pin_change_irq_enable & core_q.pin_change_irq_flag);
  assign periph_req = core_q.peripheral_group_enable & (|(preq_q & pen_q));

  // Registered so the core sees a clean level; costs one cycle of latency
  always_ff @(posedge CLK)
  begin
    if (RESET)
      core_irq_q <= 1'b0;
    else
      core_irq_q <= core_q.global_irq_enable & (core_req | periph_req);
  end

  always_ff @(posedge CLK)
  begin
    if (RESET)
      evt_irq_q <= 1'b0;
    else
      evt_irq_q <= |(stat_q & mask_q);
  end

  // ****************************************************************
  // APB answer
  // ****************************************************************
  always_comb
  begin
    rdata = `RST_BYTE;
    unique case (sel)
      SEL_CORE: rdata = core_q;
      SEL_PREQ: rdata = preq_q;
      SEL_PEN:  rdata = pen_q;
      SEL_STAT: rdata = stat_q[7:0];
      SEL_MASK: rdata = mask_q[7:0];
      SEL_CFG:  rdata = cfg_q;
      SEL_NONE: rdata = `RST_BYTE;
    endcase
  end

  // No wait state: answer is registered in setup, shown in the first access cycle
  always_ff @(posedge CLK)
  begin
    if (RESET)
      pready_q <= 1'b0;
    else
      pready_q <= PSEL & ~PENABLE & ~pready_q;
  end

  always_ff @(posedge CLK)
  begin
    if (RESET)
      pslverr_q <= 1'b0;
    else
      pslverr_q <= PSEL & ~PENABLE & ~pready_q & (sel == SEL_NONE);
  end

  always_ff @(posedge CLK)
  begin
    if (RESET)
      prdata_q <= 32'h0000_0000;
    else if (PSEL & ~PENABLE & ~PWRITE)
    begin
      unique case (sel)
        SEL_STAT: prdata_q <= {21'h0, stat_q};
        SEL_MASK: prdata_q <= {21'h0, mask_q};
        default:  prdata_q <= {24'h000000, rdata};
      endcase
    end
    else
      prdata_q <= 32'h0000_0000;
  end

  assign PRDATA   = prdata_q;
  assign PREADY   = pready_q;
  assign PSLVERR  = pslverr_q;
  assign CORE_IRQ = core_irq_q;
  assign EVT_IRQ  = evt_irq_q;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RESET);

  sequence s_core_write;
    wr_en && sel == SEL_CORE;
  endsequence

  sequence s_preq_idle;
    !(wr_en && sel == SEL_PREQ);
  endsequence

  a_t0_flag_sets: assert property (
    TIMER0_OVERFLOW |=> core_q.timer0_overflow_flag)
    else $error("timer0 flag not set after overflow");

  a_nv_done_sets: assert property (
    PERIPH_EVENT[`BIT_NV_DONE] |=> preq_q[`BIT_NV_DONE])
    else $error("write done flag not set");

  a_nv_done_holds: assert property (
    preq_q[`BIT_NV_DONE] ##0 s_preq_idle |=> preq_q[`BIT_NV_DONE])
    else $error("write done flag dropped without a write");

  a_t2_match_sets: assert property (
    PERIPH_EVENT[`BIT_T2_MATCH] |=> preq_q[`BIT_T2_MATCH])
    else $error("timer2 match flag not set");

  a_event_wins: assert property (
    s_core_write ##0 (PIN_CHANGE && !PWDATA[`BIT_PINCHG_FLAG])
      |=> core_q.pin_change_irq_flag)
    else $error("clearing write beat a same-cycle event");

  a_global_blocks: assert property (
    !core_q.global_irq_enable |=> !CORE_IRQ)
    else $error("request raised with global enable clear");

  a_periph_group: assert property (
    core_q.global_irq_enable && !core_q.peripheral_group_enable && !core_req
      |=> !CORE_IRQ)
    else $error("peripheral request without group enable");

  a_t1_request: assert property (
    core_q.global_irq_enable && core_q.peripheral_group_enable
      && pen_q[`BIT_T1_OVF] && preq_q[`BIT_T1_OVF] |=> CORE_IRQ)
    else $error("timer1 overflow did not request");

  a_core_request: assert property (
    core_q.global_irq_enable && core_q.timer0_overflow_enable
      && core_q.timer0_overflow_flag |=> CORE_IRQ)
    else $error("enabled core flag did not request");

  a_bank_alias: assert property (
    PSEL && !PENABLE && !PWRITE && PADDR == {2'b00, `IDX_CORE_CTRL_B1, 2'b00}
      |=> PRDATA[7:0] == $past(core_q))
    else $error("second bank does not read core control");

  a_enable_write: assert property (
    s_core_write |=> core_q.global_irq_enable == $past(PWDATA[`BIT_GLOBAL_EN])
      && core_q.timer0_overflow_enable == $past(PWDATA[`BIT_T0_EN]))
    else $error("core enables not written");

  a_apb_answer: assert property (
    PSEL && !PENABLE ##1 PSEL && PENABLE |-> PREADY)
    else $error("no answer one cycle after setup");

endmodule // interrupt_enable_flag_unit
`default_nettype wire

/* dv/event_source_model.sv */
// Model of the peripheral event sources and the external interrupt pin
`timescale 1ns/100ps
`default_nettype none

module event_source_model
(
  // Clock
  input  wire logic       CLK,
  // Events and pin
  output var  logic       TIMER0_OVERFLOW,
  output var  logic       PIN_CHANGE,
  output var  logic [7:0] PERIPH_EVENT,
  output var  logic       EXT_IRQ_PIN
);

  initial
  begin
    TIMER0_OVERFLOW = 1'b0;
    PIN_CHANGE      = 1'b0;
    PERIPH_EVENT    = 8'h00;
    EXT_IRQ_PIN     = 1'b0;
  end

  // One-cycle pulses; caller stands just after a rising edge
  task automatic pulse(input logic t0, input logic pc, input logic [7:0] pe);
    TIMER0_OVERFLOW <= t0;
    PIN_CHANGE      <= pc;
    PERIPH_EVENT    <= pe;
    @(posedge CLK);
    TIMER0_OVERFLOW <= 1'b0;
    PIN_CHANGE      <= 1'b0;
    PERIPH_EVENT    <= 8'h00;
  endtask

  // Pin level; the unit synchronises it itself
  task automatic pin(input logic v);
    EXT_IRQ_PIN <= v;
  endtask

endmodule // event_source_model
`default_nettype wire

/* dv/test_interrupt_enable_flag_unit.sv */
// Self-checking bench for the interrupt enable/flag unit
`timescale 1ns/100ps
`default_nettype none
`include "irq_defs.svh"

module test_interrupt_enable_flag_unit;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        t0;
  logic        pc;
  logic [7:0]  pe;
  logic        ext;
  logic        core_irq;
  logic        evt_irq;
  logic [31:0] d;
  logic        e;
  int          n_errors = 0;
  int          comparisons = 0;
  int          cyc = 0;

  always #2 clk = ~clk;

  interrupt_enable_flag_unit DUT (.CLK(clk), .RESET(reset), .PADDR(paddr), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .TIMER0_OVERFLOW(t0), .PIN_CHANGE(pc),
    .PERIPH_EVENT(pe), .EXT_IRQ_PIN(ext), .CORE_IRQ(core_irq), .EVT_IRQ(evt_irq));

  event_source_model p (.CLK(clk), .TIMER0_OVERFLOW(t0), .PIN_CHANGE(pc),
    .PERIPH_EVENT(pe), .EXT_IRQ_PIN(ext));

  // ****************************************
  // Bus and compare tasks
  // ****************************************
  function automatic logic [11:0] a(input logic [7:0] i);
    return {2'b00, i, 2'b00};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chkb(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask

  // Caller stands just after a rising edge; no cycle count is assumed
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= ad;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    d = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // One idle edge, so a following call never drives psel twice in one step
    @(posedge clk);
  endtask

  task automatic wr(input logic [11:0] ad, input logic [31:0] wd);
    apb(1'b1, ad, wd);
    chkb(e, 1'b0);
  endtask

  task automatic rd(input logic [11:0] ad, input logic [31:0] exp);
    apb(1'b0, ad, 32'h0);
    chk(d, exp);
    chkb(e, 1'b0);
  endtask

  task automatic settle();
    repeat (3) @(posedge clk);
  endtask

  task automatic summarize();
    if (n_errors == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Ceiling is far above the roughly 150 cycles the sequence needs
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      n_errors++;
      summarize();
    end
  end

  // ****************************************
  // Test sequence
  // ****************************************
  initial
  begin
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    rd(a(`IDX_CORE_CTRL_B0), 32'h0);
    rd(a(`IDX_PERIPH_REQ), 32'h0);
    rd(a(`IDX_PERIPH_EN), 32'h0);
    rd(a(`IDX_CONFIG), 32'h1);
    apb(1'b0, 12'h3fc, 32'h0);
    chkb(e, 1'b1);
    chk(d, 32'h0);
    wr(a(`IDX_CORE_CTRL_B0), 32'h38);
    rd(a(`IDX_CORE_CTRL_B1), 32'h38);
    p.pulse(1'b1, 1'b1, 8'h00);
    settle();
    rd(a(`IDX_CORE_CTRL_B1), 32'h3d);
    chkb(core_irq, 1'b0);
    wr(a(`IDX_CORE_CTRL_B1), 32'hbd);
    settle();
    chkb(core_irq, 1'b1);
    wr(a(`IDX_CORE_CTRL_B0), 32'h3d);
    settle();
    chkb(core_irq, 1'b0);
    wr(a(`IDX_CORE_CTRL_B0), 32'h00);
    rd(a(`IDX_CORE_CTRL_B0), 32'h00);
    p.pulse(1'b0, 1'b0, 8'h93);
    settle();
    rd(a(`IDX_PERIPH_REQ), 32'h83);
    wr(a(`IDX_PERIPH_EN), 32'h01);
    wr(a(`IDX_CORE_CTRL_B0), 32'h80);
    settle();
    chkb(core_irq, 1'b0);
    wr(a(`IDX_CORE_CTRL_B0), 32'hc0);
    settle();
    chkb(core_irq, 1'b1);
    wr(a(`IDX_PERIPH_EN), 32'h00);
    settle();
    chkb(core_irq, 1'b0);
    rd(a(`IDX_PERIPH_REQ), 32'h83);
    // Event lands on the very edge of the clearing write
    fork
      wr(a(`IDX_PERIPH_REQ), 32'h00);
      begin
        @(posedge clk);
        p.pulse(1'b0, 1'b0, 8'h02);
      end
    join
    rd(a(`IDX_PERIPH_REQ), 32'h02);
    p.pin(1'b1);
    repeat (6) @(posedge clk);
    rd(a(`IDX_CORE_CTRL_B0), 32'hc2);
    rd(a(`IDX_EVT_STATUS), 32'h783);
    chkb(evt_irq, 1'b0);
    wr(a(`IDX_EVT_MASK), 32'h100);
    settle();
    chkb(evt_irq, 1'b1);
    wr(a(`IDX_EVT_STATUS), 32'h100);
    settle();
    chkb(evt_irq, 1'b0);
    rd(a(`IDX_EVT_STATUS), 32'h683);
    // Clearing write to core control meets a pin-change pulse; then falling edge mode
    wr(a(`IDX_CONFIG), 32'h0);
    fork
      wr(a(`IDX_CORE_CTRL_B0), 32'h00);
      begin
        @(posedge clk);
        p.pulse(1'b0, 1'b1, 8'h00);
      end
    join
    rd(a(`IDX_CORE_CTRL_B0), 32'h01);
    p.pin(1'b0);
    repeat (6) @(posedge clk);
    rd(a(`IDX_CORE_CTRL_B0), 32'h03);
    // Mid-run reset returns every register to its reset value
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    chkb(core_irq, 1'b0);
    chkb(evt_irq, 1'b0);
    rd(a(`IDX_CORE_CTRL_B0), 32'h0);
    rd(a(`IDX_EVT_STATUS), 32'h0);
    rd(a(`IDX_CONFIG), 32'h1);
    summarize();
  end

endmodule // test_interrupt_enable_flag_unit
`default_nettype wire
